// ### rtl/wutc_pkg.sv
// wutc_pkg: shared constants and types for the wake-up timer controller
package wutc_pkg;

  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;

  // register byte addresses
  localparam logic [10:0] ADDR_TIMER_CONFIG_PRESCALE = 11'h316;
  localparam logic [10:0] ADDR_TIMER_CONFIG_WAKE = 11'h317;
  localparam logic [10:0] ADDR_RELOAD_LOW_BYTE = 11'h318;
  localparam logic [10:0] ADDR_RELOAD_HIGH_BYTE = 11'h319;
  localparam logic [10:0] ADDR_TIMER_CONTROL = 11'h31A;
  localparam logic [10:0] ADDR_SLOW_OSCILLATOR_STATUS = 11'h31B;
  localparam logic [10:0] ADDR_COUNT_LOW = 11'h31C;
  localparam logic [10:0] ADDR_COUNT_HIGH = 11'h31D;
  localparam logic [10:0] ADDR_INT_OUT1_ENABLE_LOW = 11'h31E;
  localparam logic [10:0] ADDR_INT_OUT2_ENABLE_LOW = 11'h31F;

  // field positions
  localparam int unsigned PRESCALE_LSB = 0;
  localparam int unsigned PRESCALE_W = 3;
  localparam int unsigned WAKE_CLK_EN_BIT = 0;
  localparam int unsigned WAKE_CLK_SEL_BIT = 3;
  localparam int unsigned WAKE_ARM_BIT = 7;
  localparam int unsigned CTRL_FLAG_RESET_BIT = 0;
  localparam int unsigned CTRL_CAL_BIT = 1;
  localparam int unsigned STAT_CAL_DONE_BIT = 0;
  localparam int unsigned STAT_FLAG_BIT = 1;
  localparam int unsigned STAT_RUN_BIT = 2;
  localparam int unsigned IRQ_EN_TIMEOUT_BIT = 0;

  // reset values
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [7:0] RST_RELOAD_LOW = 8'h00;
  localparam logic [7:0] RST_RELOAD_HIGH = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;

  // timing
  localparam int unsigned SYS_CLK_HZ = 40000000;
  localparam int unsigned CAL_TIME_US = 1000;
  localparam int unsigned CAL_CYCLES = (SYS_CLK_HZ / 1000000) * CAL_TIME_US;
  localparam int unsigned SLOW_TICK_HZ = 32768;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } wutc_reg_req_t;

  typedef enum logic [1:0] {
    WUTC_SRC_RC,
    WUTC_SRC_XTAL
  } wutc_src_t;

  // tick division per 3-bit code
  function automatic logic [16:0] wutc_divider(input logic [2:0] code);
    unique case (code)
      3'h0: wutc_divider = 17'h00001;
      3'h1: wutc_divider = 17'h00004;
      3'h2: wutc_divider = 17'h00008;
      3'h3: wutc_divider = 17'h00010;
      3'h4: wutc_divider = 17'h00080;
      3'h5: wutc_divider = 17'h00400;
      3'h6: wutc_divider = 17'h02000;
      3'h7: wutc_divider = 17'h10000;
    endcase
  endfunction

endpackage

// ### rtl/wutc_prescaler.sv
// wutc_prescaler: programmable divider of the slow tick enable
`timescale 1ns/10ps
module wutc_prescaler #(
  parameter int unsigned CNT_W = 17
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [2:0] code_i,
  output logic tick_o
);
  import wutc_pkg::*;

  // elaboration guard: rejects CNT_W below 17; the largest divider's last count, 65535, fits in 16 bits
  if (CNT_W < 17) begin : g_cnt_w_check
    $error("wutc_prescaler: CNT_W too small for largest divider");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;

  assign last = CNT_W'(wutc_divider(code_i) - 17'h00001);

  // counts slow ticks; restarts whenever the timer is stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= '0;
    end else if (tick_i) begin
      cnt_q <= (cnt_q >= last) ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= run_i && tick_i && (cnt_q >= last);
    end
  end

endmodule // wutc_prescaler

// ### rtl/wutc_top.sv
// wutc_top: wake-up timer with prescaler, down counter and RC calibration
`timescale 1ns/10ps
module wutc_top #(
  parameter int unsigned CAL_CNT = wutc_pkg::CAL_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [wutc_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [wutc_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic REG_RE_I,
  input wire logic RC_TICK_I,
  input wire logic XTAL_TICK_I,
  input wire logic SLEEP_I,
  output logic [wutc_pkg::DATA_W-1:0] REG_RDATA_O,
  output logic IRQ1_O,
  output logic IRQ2_O,
  output logic WAKE_O,
  output logic CAL_RUN_O
);
  import wutc_pkg::*;

  // elaboration guard: a zero-length calibration would wrap the counter and run 2^32 cycles before done
  if (CAL_CNT < 1) begin : g_cal_cnt_check
    $error("wutc_top: CAL_CNT must be at least one");
  end

  wutc_reg_req_t req;
  assign req = '{addr: REG_ADDR_I, wdata: REG_WDATA_I, we: REG_WE_I, re: REG_RE_I};

  function automatic logic hit(input wutc_reg_req_t r, input logic [10:0] a);
    hit = r.we && (r.addr == a);
  endfunction

  logic [7:0] prescale_q;
  logic [7:0] wake_q;
  logic [7:0] reload_lo_q;
  logic [7:0] reload_hi_q;
  logic [7:0] ctrl_q;
  logic [7:0] irq1_en_q;
  logic [7:0] irq2_en_q;

  // register writes
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      prescale_q <= RST_PRESCALE;
      wake_q <= RST_WAKE;
      reload_lo_q <= RST_RELOAD_LOW;
      reload_hi_q <= RST_RELOAD_HIGH;
      ctrl_q <= RST_CONTROL;
      irq1_en_q <= RST_IRQ_EN;
      irq2_en_q <= RST_IRQ_EN;
    end else begin
      if (hit(req, ADDR_TIMER_CONFIG_PRESCALE)) prescale_q <= req.wdata;
      if (hit(req, ADDR_TIMER_CONFIG_WAKE)) wake_q <= req.wdata;
      if (hit(req, ADDR_RELOAD_LOW_BYTE)) reload_lo_q <= req.wdata;
      if (hit(req, ADDR_RELOAD_HIGH_BYTE)) reload_hi_q <= req.wdata;
      if (hit(req, ADDR_TIMER_CONTROL)) ctrl_q <= req.wdata;
      if (hit(req, ADDR_INT_OUT1_ENABLE_LOW)) irq1_en_q <= req.wdata;
      if (hit(req, ADDR_INT_OUT2_ENABLE_LOW)) irq2_en_q <= req.wdata;
    end
  end

  // tick pins are asynchronous to the system clock
  logic [1:0] rc_sync_q;
  logic [1:0] xt_sync_q;
  logic tick_lvl_q;
  logic tick_en;
  wutc_src_t src;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rc_sync_q <= 2'h0;
      xt_sync_q <= 2'h0;
    end else begin
      rc_sync_q <= {rc_sync_q[0], RC_TICK_I};
      xt_sync_q <= {xt_sync_q[0], XTAL_TICK_I};
    end
  end

  assign src = wake_q[WAKE_CLK_SEL_BIT] ? WUTC_SRC_XTAL : WUTC_SRC_RC;

  logic tick_sel;
  always_comb begin
    unique case (src)
      WUTC_SRC_XTAL: tick_sel = xt_sync_q[1];
      default: tick_sel = rc_sync_q[1];
    endcase
  end

  // rising edge of the chosen slow clock becomes a one-cycle enable
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tick_lvl_q <= 1'b0;
    end else begin
      tick_lvl_q <= tick_sel;
    end
  end
  assign tick_en = tick_sel && !tick_lvl_q;

  logic run;
  logic run_q;
  logic pre_tick;
  assign run = wake_q[WAKE_CLK_EN_BIT];

  wutc_prescaler #(
    .CNT_W(17)
  ) u_prescaler (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .run_i(run),
    .tick_i(tick_en),
    .code_i(prescale_q[PRESCALE_LSB +: PRESCALE_W]),
    .tick_o(pre_tick)
  );

  // down counter; reloads on enable and after reaching zero
  logic [15:0] count_q;
  logic [15:0] reload;
  logic hit_zero;
  assign reload = {reload_hi_q, reload_lo_q};

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      count_q <= 16'h0000;
    end else if (run && !run_q) begin
      count_q <= reload;
    end else if (run && pre_tick) begin
      count_q <= (count_q == 16'h0000) ? reload : count_q - 16'h0001;
    end
  end

  // zero reached on this decrement
  assign hit_zero = run && pre_tick && (count_q == 16'h0001);

  // sticky timeout flag; a new timeout beats a simultaneous reset
  logic flag_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      flag_q <= 1'b0;
    end else if (hit_zero) begin
      flag_q <= 1'b1;
    end else if (ctrl_q[CTRL_FLAG_RESET_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      IRQ1_O <= 1'b0;
      IRQ2_O <= 1'b0;
    end else begin
      IRQ1_O <= flag_q && irq1_en_q[IRQ_EN_TIMEOUT_BIT];
      IRQ2_O <= flag_q && irq2_en_q[IRQ_EN_TIMEOUT_BIT];
    end
  end

  // wake is held while asleep, armed and an enabled timeout is pending
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      WAKE_O <= 1'b0;
    end else begin
      WAKE_O <= SLEEP_I && wake_q[WAKE_ARM_BIT] && flag_q
                && (irq1_en_q[IRQ_EN_TIMEOUT_BIT] || irq2_en_q[IRQ_EN_TIMEOUT_BIT]);
    end
  end

  // calibration: only a 0-to-1 change of the control bit starts it
  logic cal_done_q;
  logic [31:0] cal_cnt_q;
  logic cal_start;
  assign cal_start = hit(req, ADDR_TIMER_CONTROL) && req.wdata[CTRL_CAL_BIT]
                     && !ctrl_q[CTRL_CAL_BIT];

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      cal_done_q <= 1'b0;
      cal_cnt_q <= 32'h00000000;
      CAL_RUN_O <= 1'b0;
    end else begin
      if (cal_start) begin
        CAL_RUN_O <= 1'b1;
        cal_done_q <= 1'b0;
        cal_cnt_q <= 32'(CAL_CNT - 1);
      end else if (CAL_RUN_O) begin
        if (cal_cnt_q == 32'h00000000) begin
          CAL_RUN_O <= 1'b0;
          cal_done_q <= 1'b1;
        end else begin
          cal_cnt_q <= cal_cnt_q - 32'h00000001;
        end
      end
    end
  end

  // readback, registered; unmapped addresses read zero
  logic [7:0] rd;
  always_comb begin
    unique case (req.addr)
      ADDR_TIMER_CONFIG_PRESCALE: rd = prescale_q;
      ADDR_TIMER_CONFIG_WAKE: rd = wake_q;
      ADDR_RELOAD_LOW_BYTE: rd = reload_lo_q;
      ADDR_RELOAD_HIGH_BYTE: rd = reload_hi_q;
      ADDR_TIMER_CONTROL: rd = ctrl_q;
      ADDR_SLOW_OSCILLATOR_STATUS: begin
        rd = 8'h00;
        rd[STAT_CAL_DONE_BIT] = cal_done_q;
        rd[STAT_FLAG_BIT] = flag_q;
        rd[STAT_RUN_BIT] = run_q;
      end
      ADDR_COUNT_LOW: rd = count_q[7:0];
      ADDR_COUNT_HIGH: rd = count_q[15:8];
      ADDR_INT_OUT1_ENABLE_LOW: rd = irq1_en_q;
      ADDR_INT_OUT2_ENABLE_LOW: rd = irq2_en_q;
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (req.re) begin
      REG_RDATA_O <= rd;
    end
  end

endmodule // wutc_top

// ### bench/wutc_top_checker.sv
// wutc_top_checker: port-level assertions for the wake-up timer
`timescale 1ns/10ps
module wutc_top_checker #(
  parameter int unsigned CAL_CNT = wutc_pkg::CAL_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [wutc_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [wutc_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WE_I,
  input wire logic SLEEP_I,
  input wire logic IRQ1_O,
  input wire logic IRQ2_O,
  input wire logic WAKE_O,
  input wire logic CAL_RUN_O
);
  import wutc_pkg::*;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic en1_q, en2_q, clr_q, arm_q, cal_wr;
  int run_q;
  assign cal_wr = REG_WE_I && REG_ADDR_I == ADDR_TIMER_CONTROL && REG_WDATA_I[CTRL_CAL_BIT];
  // shadow of the register bits that gate the outputs
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      {en1_q, en2_q, clr_q, arm_q} <= '0;
    end else if (REG_WE_I) begin
      if (REG_ADDR_I == ADDR_INT_OUT1_ENABLE_LOW) en1_q <= REG_WDATA_I[IRQ_EN_TIMEOUT_BIT];
      if (REG_ADDR_I == ADDR_INT_OUT2_ENABLE_LOW) en2_q <= REG_WDATA_I[IRQ_EN_TIMEOUT_BIT];
      if (REG_ADDR_I == ADDR_TIMER_CONTROL) clr_q <= REG_WDATA_I[CTRL_FLAG_RESET_BIT];
      if (REG_ADDR_I == ADDR_TIMER_CONFIG_WAKE) arm_q <= REG_WDATA_I[WAKE_ARM_BIT];
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !CAL_RUN_O) run_q <= 0;
    else run_q <= run_q + 1;
  end
  chk_irq1_enable: assert property (IRQ1_O |-> $past(en1_q))
    else $error("irq1 high with its enable off");
  chk_irq2_enable: assert property (IRQ2_O |-> $past(en2_q))
    else $error("irq2 high with its enable off");
  chk_irq1_hold: assert property ($fell(IRQ1_O) |->
    !$past(en1_q) || $past(clr_q, 2) || $past(RST_I)) else $error("irq1 dropped unasked");
  chk_irq2_hold: assert property ($fell(IRQ2_O) |->
    !$past(en2_q) || $past(clr_q, 2) || $past(RST_I)) else $error("irq2 dropped unasked");
  chk_wake_gate: assert property (WAKE_O |-> $past(SLEEP_I) && $past(arm_q))
    else $error("wake without sleep and arming");
  chk_wake_irq: assert property (WAKE_O |-> IRQ1_O || IRQ2_O)
    else $error("wake without an enabled timeout");
  chk_cal_start: assert property ($rose(CAL_RUN_O) |-> $past(cal_wr) || $past(cal_wr, 2))
    else $error("calibration started by itself");
  chk_cal_length: assert property ($fell(CAL_RUN_O) && !$past(RST_I) |-> run_q == CAL_CNT)
    else $error("calibration length wrong");
  cov_irq1: cover property ($rose(IRQ1_O));
  cov_irq2: cover property ($rose(IRQ2_O));
  cov_wake: cover property ($rose(WAKE_O));
  cov_cal: cover property ($fell(CAL_RUN_O));
endmodule // wutc_top_checker
bind wutc_top wutc_top_checker #(.CAL_CNT(CAL_CNT)) u_checker (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WE_I(REG_WE_I), .SLEEP_I(SLEEP_I),
  .IRQ1_O(IRQ1_O), .IRQ2_O(IRQ2_O), .WAKE_O(WAKE_O), .CAL_RUN_O(CAL_RUN_O)
);

// ### bench/wutc_top_tb.sv
// wutc_top_tb: self-checking bench for the wake-up timer
`timescale 1ns/10ps
module wutc_top_tb;
  import wutc_pkg::*;
  logic clk = 0, rst = 1, we = 0, re = 0, slp = 0, rc = 0, xt = 0, rv = 0, fast = 0;
  logic [10:0] addr = '0;
  logic [7:0] wd = '0, rdata;
  logic irq1, irq2, wake, cal;
  int miscompares = 0, samples_checked = 0, tcnt = 0;
  int dv[8] = '{1, 4, 8, 16, 128, 1024, 8192, 65536};
  logic [7:0] expq[$];
  wutc_top #(.CAL_CNT(8)) u_dut (
    .CLK_SYS_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
    .REG_WE_I(we), .REG_RE_I(re), .RC_TICK_I(rc), .XTAL_TICK_I(xt),
    .SLEEP_I(slp), .REG_RDATA_O(rdata), .IRQ1_O(irq1), .IRQ2_O(irq2),
    .WAKE_O(wake), .CAL_RUN_O(cal)
  );
  initial forever #12.5 clk = ~clk;
  // ticks far faster than 32.768 kHz to keep the run short; unequal rates expose the source
  always @(posedge clk) begin
    tcnt <= tcnt + 1;
    // fast mode gives one rc edge every two cycles so the two largest codes fit the run
    if (fast) rc <= ~rc;
    else if (tcnt % 10 == 0) rc <= ~rc;
    if (tcnt % 14 == 0) xt <= ~xt;
    rv <= re;
    if (rv) cmp(rdata, expq.pop_front());
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    expq.push_back(e);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
  initial begin
    logic [2:0] c;
    logic [7:0] rl, w;
    logic en1, en2, arm;
    int n, k;
    void'($urandom(98));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_SLOW_OSCILLATOR_STATUS, 8'h00);
    rd(11'h300, 8'h00);
    w = 8'($urandom);
    wr(ADDR_RELOAD_HIGH_BYTE, w);
    rd(ADDR_RELOAD_HIGH_BYTE, w);
    wr(ADDR_TIMER_CONTROL, 8'h02);
    @(posedge clk);
    cmp({7'h00, cal}, 8'h01);
    repeat (12) @(posedge clk);
    rd(ADDR_SLOW_OSCILLATOR_STATUS, 8'h01);
    wr(ADDR_TIMER_CONTROL, 8'h02);
    @(posedge clk);
    cmp({7'h00, cal}, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    for (int i = 0; i < 6; i++) begin
      c = 3'(i);
      rl = (i < 5) ? 8'($urandom_range(3, 1)) : 8'h01;
      w = 8'($urandom);
      en1 = w[0];
      en2 = ~w[0] | w[1];
      arm = c[2] | c[0];
      wr(ADDR_TIMER_CONFIG_WAKE, {4'h0, c[0], 3'h0});
      wr(ADDR_RELOAD_LOW_BYTE, rl);
      wr(ADDR_RELOAD_HIGH_BYTE, 8'h00);
      wr(ADDR_TIMER_CONFIG_PRESCALE, {5'h00, c});
      wr(ADDR_TIMER_CONTROL, 8'h01);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      wr(ADDR_INT_OUT1_ENABLE_LOW, {7'h00, en1});
      wr(ADDR_INT_OUT2_ENABLE_LOW, {7'h00, en2});
      // start mid-period so no tick straddles the enable
      @(posedge (c[0] ? xt : rc));
      repeat (4) @(posedge clk);
      wr(ADDR_TIMER_CONFIG_WAKE, {arm, 3'h0, c[0], 3'h1});
      slp <= c[1];
      n = int'(rl) * dv[c];
      k = 0;
      // one tick of slack so a missing or late timeout shows up in k
      while (irq1 !== 1'b1 && irq2 !== 1'b1 && k <= n + 1) begin
        @(posedge (c[0] ? xt : rc));
        k++;
      end
      cmp({7'h00, 1'(k == n + 1)}, 8'h01);
      cmp({6'h00, irq2, irq1}, {6'h00, en2, en1});
      cmp({7'h00, wake}, {7'h00, arm & c[1]});
      rd(ADDR_COUNT_LOW, 8'h00);
      rd(ADDR_SLOW_OSCILLATOR_STATUS, 8'h07);
      wr(ADDR_TIMER_CONFIG_WAKE, 8'h00);
      repeat (3) @(posedge (c[0] ? xt : rc));
      cmp({6'h00, irq2, irq1}, {6'h00, en2, en1});
      wr(ADDR_TIMER_CONTROL, 8'h01);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      cmp({5'h00, wake, irq2, irq1}, 8'h00);
      slp <= 1'b0;
    end
    // code 110 steps once after 8192 ticks; code 111 must not have stepped yet
    fast <= 1'b1;
    for (int i = 6; i < 8; i++) begin
      wr(ADDR_TIMER_CONFIG_WAKE, 8'h00);
      wr(ADDR_RELOAD_LOW_BYTE, 8'h02);
      wr(ADDR_TIMER_CONFIG_PRESCALE, 8'(i));
      wr(ADDR_TIMER_CONFIG_WAKE, 8'h01);
      repeat (2 * dv[6] + 40) @(posedge clk);
      rd(ADDR_COUNT_LOW, (i == 6) ? 8'h01 : 8'h02);
    end
    wrap_up;
  end
endmodule // wutc_top_tb
